// ---- bbc_exec_map.vh ----
// constants of the branch and bit-clear execution block
// assumes byte-wide memory bus, 16-bit addresses, 32-bit APB data
`ifndef BBC_EXEC_MAP_VH
`define BBC_EXEC_MAP_VH

// ------------------------------------------------------------
// APB register byte offsets
// ------------------------------------------------------------
`define BBC_OFS_CTRL     8'h00
`define BBC_OFS_PC       8'h04
`define BBC_OFS_CCR      8'h08
`define BBC_OFS_IX       8'h0c
`define BBC_OFS_IY       8'h10
`define BBC_OFS_STAT     8'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BBC_CTRL_RUN     0
`define BBC_CTRL_ERR     1
`define BBC_STAT_BUSY    8
`define BBC_CCR_C        0
`define BBC_CCR_V        1
`define BBC_CCR_Z        2
`define BBC_CCR_N        3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BBC_RST_PC       16'h0000
`define BBC_RST_CCR      8'h00
`define BBC_RST_IDX      16'h0000

// ------------------------------------------------------------
// opcodes and fixed addresses
// ------------------------------------------------------------
`define BBC_OP_CLR_DIR   8'h15
`define BBC_OP_CLR_IDX   8'h1d
`define BBC_OP_PREFIX_Y  8'h18
`define BBC_OP_BR_HI     4'h2
`define BBC_DUMMY_ADDR   16'hffff
`define BBC_PAGE_ZERO    8'h00

`endif

// ---- bbc_exec.v ----
// branch family and masked bit clear execution core with APB control
// assumes single-cycle memory: mem_rdata valid by the edge ending each bus cycle
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "bbc_exec_map.vh"

// Functional notes
// - opcode 24 branches when carry clear
// - opcode 25 branches when carry set
// - opcode 27 branches when zero set
// - branch: opcode, offset, dummy all-ones read
// - branches never change condition codes
// - clear memory bits selected by mask ones
// - unmasked bits written back unchanged
// - bit clear takes six, seven, eight cycles
// - full branch family opcode to condition map
module bbc_exec (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [15:0] mem_addr,
    input  wire [7:0]  mem_rdata,
    output reg  [7:0]  mem_wdata,
    output reg         mem_rw
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_OPC  = 4'h1;
    localparam [3:0] ST_PRE  = 4'h2;
    localparam [3:0] ST_ARG  = 4'h3;
    localparam [3:0] ST_IDX  = 4'h4;
    localparam [3:0] ST_OPR  = 4'h5;
    localparam [3:0] ST_MSK  = 4'h6;
    localparam [3:0] ST_MDM  = 4'h7;
    localparam [3:0] ST_WR   = 4'h8;
    localparam [3:0] ST_BDM  = 4'h9;

    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [15:0] pc_reg;
    reg  [15:0] pc_next;
    reg  [15:0] ea_reg;
    reg  [15:0] ea_next;
    reg  [7:0]  condition_code_reg;
    reg  [15:0] ix_reg;
    reg  [15:0] iy_reg;
    reg  [7:0]  op_reg;
    reg  [7:0]  arg_reg;
    reg  [7:0]  opnd_reg;
    reg  [7:0]  msk_reg;
    reg         yidx_reg;
    reg         run_reg;
    reg         err_reg;
    reg         bad_op;
    reg         br_true;
    reg  [15:0] addr_next;

    wire        apb_wr   = psel & penable & pwrite;
    wire        hit      = (paddr == `BBC_OFS_CTRL) | (paddr == `BBC_OFS_PC) |
                           (paddr == `BBC_OFS_CCR) | (paddr == `BBC_OFS_IX) |
                           (paddr == `BBC_OFS_IY) | (paddr == `BBC_OFS_STAT);
    wire        flag_c   = condition_code_reg[`BBC_CCR_C];
    wire        flag_v   = condition_code_reg[`BBC_CCR_V];
    wire        flag_z   = condition_code_reg[`BBC_CCR_Z];
    wire        flag_n   = condition_code_reg[`BBC_CCR_N];
    wire        is_branch = (op_reg[7:4] == `BBC_OP_BR_HI);
    wire [15:0] rel_ext  = {{8{arg_reg[7]}}, arg_reg};
    wire        taken    = op_reg[0] ? br_true : ~br_true;

    // ------------------------------------------------------------
    // branch condition: odd opcode takes on the condition, even on its inverse
    // ------------------------------------------------------------
    always @* begin
        case (op_reg[3:1])
            3'h0:    br_true = 1'b0;
            3'h1:    br_true = flag_c | flag_z;
            3'h2:    br_true = flag_c;
            3'h3:    br_true = flag_z;
            3'h4:    br_true = flag_v;
            3'h5:    br_true = flag_n;
            3'h6:    br_true = flag_n ^ flag_v;
            default: br_true = flag_z | (flag_n ^ flag_v);
        endcase
    end

    // ------------------------------------------------------------
    // sequencer: one state per bus cycle
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        pc_next    = pc_reg;
        ea_next    = ea_reg;
        bad_op     = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (run_reg) begin
                    state_next = ST_OPC;
                end
            end
            ST_OPC: begin
                pc_next = pc_reg + 16'h0001;
                if (mem_rdata == `BBC_OP_PREFIX_Y) begin
                    state_next = ST_PRE;
                end else if (mem_rdata == `BBC_OP_CLR_DIR || mem_rdata == `BBC_OP_CLR_IDX ||
                             mem_rdata[7:4] == `BBC_OP_BR_HI) begin
                    state_next = ST_ARG;
                end else begin
                    bad_op     = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_PRE: begin
                pc_next = pc_reg + 16'h0001;
                if (mem_rdata == `BBC_OP_CLR_IDX) begin
                    state_next = ST_ARG;
                end else begin
                    bad_op     = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_ARG: begin
                pc_next = pc_reg + 16'h0001;
                if (is_branch) begin
                    state_next = ST_BDM;
                end else if (op_reg == `BBC_OP_CLR_DIR) begin
                    ea_next    = {`BBC_PAGE_ZERO, mem_rdata};
                    state_next = ST_OPR;
                end else begin
                    ea_next    = (yidx_reg ? iy_reg : ix_reg) + {8'h00, mem_rdata};
                    state_next = ST_IDX;
                end
            end
            ST_IDX:  state_next = ST_OPR;
            ST_OPR:  state_next = ST_MSK;
            ST_MSK: begin
                pc_next    = pc_reg + 16'h0001;
                state_next = ST_MDM;
            end
            ST_MDM:  state_next = ST_WR;
            ST_WR:   state_next = run_reg ? ST_OPC : ST_IDLE;
            ST_BDM: begin
                if (taken) begin
                    pc_next = pc_reg + rel_ext;
                end
                state_next = run_reg ? ST_OPC : ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // address of the cycle being entered; dummy cycles read the all-ones address
    always @* begin
        case (state_next)
            ST_OPC, ST_PRE, ST_ARG, ST_MSK: addr_next = pc_next;
            ST_OPR, ST_WR:                  addr_next = ea_next;
            default:                        addr_next = `BBC_DUMMY_ADDR;
        endcase
    end

    // ------------------------------------------------------------
    // datapath and bus outputs
    // ------------------------------------------------------------
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            pc_reg    <= `BBC_RST_PC;
            ea_reg    <= 16'h0000;
            op_reg    <= 8'h00;
            arg_reg   <= 8'h00;
            opnd_reg  <= 8'h00;
            msk_reg   <= 8'h00;
            yidx_reg  <= 1'b0;
            mem_addr  <= `BBC_DUMMY_ADDR;
            mem_rw    <= 1'b1;
            mem_wdata <= 8'h00;
        end else begin
            state_reg <= state_next;
            ea_reg    <= ea_next;
            mem_addr  <= addr_next;
            mem_rw    <= (state_next != ST_WR);
            // pc is software-loadable only while the core sits idle
            if (state_reg == ST_IDLE && apb_wr && paddr == `BBC_OFS_PC) begin
                pc_reg <= pwdata[15:0];
            end else begin
                pc_reg <= pc_next;
            end
            if (state_reg == ST_OPC) begin
                op_reg   <= mem_rdata;
                yidx_reg <= (mem_rdata == `BBC_OP_PREFIX_Y);
            end
            if (state_reg == ST_ARG) begin
                arg_reg <= mem_rdata;
            end
            if (state_reg == ST_OPR) begin
                opnd_reg <= mem_rdata;
            end
            if (state_reg == ST_MSK) begin
                msk_reg <= mem_rdata;
            end
            if (state_next == ST_WR) begin
                mem_wdata <= opnd_reg & ~msk_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_reg            <= 1'b0;
            err_reg            <= 1'b0;
            condition_code_reg <= `BBC_RST_CCR;
            ix_reg             <= `BBC_RST_IDX;
            iy_reg             <= `BBC_RST_IDX;
            prdata             <= 32'h00000000;
        end else begin
            // a bad opcode stops the core; the hardware stop beats a software start
            if (bad_op) begin
                run_reg <= 1'b0;
            end else if (apb_wr && paddr == `BBC_OFS_CTRL) begin
                run_reg <= pwdata[`BBC_CTRL_RUN];
            end
            if (bad_op) begin
                err_reg <= 1'b1;
            end else if (apb_wr && paddr == `BBC_OFS_CTRL && pwdata[`BBC_CTRL_ERR]) begin
                err_reg <= 1'b0;
            end
            // the core itself never writes the flags, only software does
            if (apb_wr && paddr == `BBC_OFS_CCR) begin
                condition_code_reg <= pwdata[7:0];
            end
            if (apb_wr && paddr == `BBC_OFS_IX) begin
                ix_reg <= pwdata[15:0];
            end
            if (apb_wr && paddr == `BBC_OFS_IY) begin
                iy_reg <= pwdata[15:0];
            end
            if (psel && !penable) begin
                case (paddr)
                    `BBC_OFS_CTRL: prdata <= {30'h0, err_reg, run_reg};
                    `BBC_OFS_PC:   prdata <= {16'h0000, pc_reg};
                    `BBC_OFS_CCR:  prdata <= {24'h000000, condition_code_reg};
                    `BBC_OFS_IX:   prdata <= {16'h0000, ix_reg};
                    `BBC_OFS_IY:   prdata <= {16'h0000, iy_reg};
                    `BBC_OFS_STAT: prdata <= {23'h0, (state_reg != ST_IDLE), 4'h0, state_reg};
                    default:       prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ---- bbc_mem_model.sv ----
// byte memory that answers the core's bus in the same cycle
// assumes one bus cycle per clock and a write whenever mem_rw is low
`timescale 1ns/10ps
module bbc_mem_model (
    input  wire        clock,
    input  wire [15:0] mem_addr,
    output wire [7:0]  mem_rdata,
    input  wire [7:0]  mem_wdata,
    input  wire        mem_rw
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg = 8'h00;
    // not driven while the core writes: show the inverse of the last byte
    assign mem_rdata = mem_rw ? mem[mem_addr] : ~last_reg;
    always @(posedge clock) begin
        last_reg <= mem_rdata;
        if (!mem_rw)
            mem[mem_addr] <= mem_wdata;
    end
    initial foreach (mem[i]) mem[i] = 8'h00;
endmodule

// ---- bbc_exec_chk.sv ----
// assertions on the bus cycles and register port of the core
// assumes one clock domain with asynchronous active-low reset
`timescale 1ns/10ps
module bbc_exec_chk (
    input wire        clock,
    input wire        arst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [15:0] mem_addr,
    input wire [7:0]  mem_rdata,
    input wire [7:0]  mem_wdata,
    input wire        mem_rw
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [7:0] ccr_reg;
    wire        acc = psel && penable;
    // -----------------------------------------
    // software is the only writer of the flags
    // -----------------------------------------
    always @(posedge clock or negedge arst_n)
        if (!arst_n)
            ccr_reg <= 8'h00;
        else if (acc && pwrite && paddr == 8'h08)
            ccr_reg <= pwdata[7:0];
    chk_flags_kept: assert property (acc && !pwrite && paddr == 8'h08
        |-> prdata[7:0] == ccr_reg) else $error("flags changed");
    chk_clear_data: assert property (!mem_rw
        |-> mem_wdata == ($past(mem_rdata, 3) & ~$past(mem_rdata, 2))) else $error("bad result");
    chk_write_addr: assert property (!mem_rw
        |-> mem_addr == $past(mem_addr, 3) && $past(mem_rw, 3)) else $error("bad write addr");
    chk_dummy_first: assert property (!mem_rw
        |-> $past(mem_addr) == 16'hffff && $past(mem_rw)) else $error("no dummy read");
    chk_write_once: assert property (!mem_rw |=> mem_rw)
        else $error("long write");
    chk_dummy_read: assert property (mem_addr == 16'hffff |-> mem_rw)
        else $error("dummy cycle writes");
    chk_zero_wait: assert property (acc |-> pready)
        else $error("wait state");
    chk_unmapped_err: assert property (acc && paddr > 8'h14 |-> pslverr)
        else $error("no error response");
    cover property (!mem_rw);
    cover property (pslverr);
    cover property (mem_addr == 16'hffff ##1 mem_rw && mem_addr != 16'hffff);
endmodule
bind bbc_exec bbc_exec_chk bbc_exec_chk_i (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_rdata, .mem_wdata, .mem_rw);

// ---- testbench.sv ----
// self-checking bench for the branch and bit clear core
// assumes the core, its checker and a byte memory model on the bus
`timescale 1ns/10ps
module testbench;
    logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, op, off, mk, old;
    logic [31:0] pwdata = 32'h0, r;
    wire  [31:0] prdata;
    wire         pready, pslverr, mem_rw;
    wire  [15:0] mem_addr;
    wire  [7:0]  mem_rdata, mem_wdata;
    logic [15:0] lf = 16'h5aa5, v, w, pc, base, ea;
    logic [1:0]  m;
    logic        rec = 1'b0, serr;
    logic [24:0] tq[$], eq[$];
    int          fails = 0, cmp_count = 0, cyc = 0;
    bbc_exec bbc_exec_i (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mem_addr, .mem_rdata, .mem_wdata, .mem_rw);
    bbc_mem_model bbc_mem_model_i (.clock, .mem_addr, .mem_rdata, .mem_wdata, .mem_rw);
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (rec)
            tq.push_back({mem_rw, mem_addr, mem_rw ? 8'h00 : mem_wdata});
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish;
        end
    end
    // ----------------------------
    // helpers
    // ----------------------------
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic taken(input logic [7:0] o, input logic [3:0] f);
        logic t;
        case (o[3:1])
            3'h0: t = 1'b1;
            3'h1: t = !(f[0] | f[2]);
            3'h2: t = !f[0];
            3'h3: t = !f[2];
            3'h4: t = !f[1];
            3'h5: t = !f[3];
            3'h6: t = !(f[3] ^ f[1]);
            default: t = !(f[2] | (f[3] ^ f[1]));
        endcase
        return t ^ o[0];
    endfunction
    task automatic chk(input logic [31:0] exp, got, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input logic [15:0] a, input logic [31:0] p);
        for (int k = 0; k < 4; k++)
            bbc_mem_model_i.mem[a + k] = p[31 - 8 * k -: 8];
    endtask
    task automatic e(input logic [15:0] a, input logic rw = 1'b1, input logic [7:0] d = 8'h00);
        eq.push_back({rw, a, d});
    endtask
    // the instruction is followed by an unsupported byte, so the core stops by itself
    task automatic run(input logic [7:0] cc, input string what);
        apb(1'b1, 8'h04, {16'h0, pc});
        apb(1'b1, 8'h08, {24'h0, cc});
        tq.delete();
        rec = 1'b1;
        apb(1'b1, 8'h00, 32'h1);
        r = 32'h1;
        while (r[0] !== 1'b0)
            apb(1'b0, 8'h00, 32'h0);
        rec = 1'b0;
        chk(32'h2, {30'h0, r[1:0]}, "ctrl after stop");
        apb(1'b0, 8'h14, 32'h0);
        chk(32'h0, r, "status idle");
        apb(1'b0, 8'h08, 32'h0);
        chk({24'h0, cc}, {24'h0, r[7:0]}, "flags");
        apb(1'b1, 8'h00, 32'h2);
        while (tq.size() > 0 && tq[0][23:8] !== pc)
            void'(tq.pop_front());
        foreach (eq[k])
            chk({7'h0, eq[k]}, {7'h0, tq[k]}, what);
        eq.delete();
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk(32'h0, r, "pc reset");
        apb(1'b1, 8'h40, 32'hffff);
        chk(32'h1, {31'h0, serr}, "unmapped error");
        $display("register test done");
        for (int i = 0; i < 40; i++) begin
            v = rnd();
            w = rnd();
            op = {4'h2, i[3:0]};
            off = i == 16 ? 8'h80 : i == 17 ? 8'h7f : w[7:0];
            off = off > 8'hfd ? 8'h10 : off;
            pc = {4'h1, v[11:0]};
            load(pc, {op, off, 16'h0});
            e(pc);
            e(pc + 16'h1);
            e(16'hffff);
            ea = pc + 16'h2 + (taken(op, w[11:8]) ? {{8{off[7]}}, off} : 16'h0);
            e(ea);
            run(w[15:8], "branch trace");
            load(pc, 32'h0);
        end
        $display("branch test done");
        for (int j = 0; j < 9; j++) begin
            v = rnd();
            w = rnd();
            m = 2'(j % 3);
            mk = j == 0 ? 8'hff : j == 1 ? 8'h00 : w[7:0];
            old = v[7:0] ^ w[15:8];
            pc = {4'h1, v[11:0]};
            base = {2'b10, w[15:2]};
            ea = m == 0 ? {8'h00, v[15:8]} : (m == 1 ? base : base ^ 16'h1000) + v[15:8];
            load(pc, m == 2 ? {16'h181d, v[15:8], mk} : {m[0] ? 8'h1d : 8'h15, v[15:8], mk, 8'h0});
            bbc_mem_model_i.mem[ea] = old;
            apb(1'b1, 8'h0c, {16'h0, base});
            apb(1'b1, 8'h10, {16'h0, base ^ 16'h1000});
            e(pc);
            e(pc + 16'h1);
            if (m == 2)
                e(pc + 16'h2);
            if (m != 0)
                e(16'hffff);
            e(ea);
            e(pc + 16'h2 + m[1]);
            e(16'hffff);
            e(ea, 1'b0, old & ~mk);
            e(pc + 16'h3 + m[1]);
            run(old, "clear trace");
            chk({24'h0, old & ~mk}, {24'h0, bbc_mem_model_i.mem[ea]}, "cleared byte");
            load(pc, 32'h0);
            bbc_mem_model_i.mem[ea] = 8'h00;
        end
        $display("bit clear test done");
        tally_and_finish;
    end
endmodule
